// ### hdl/jtp_pkg.sv
// jtp_pkg: constants and types for the test access port
package jtp_pkg;
   localparam int IR_W      = 4;
   localparam int SYNC_W    = 3;
   localparam logic [3:0] IR_RESET_VAL = 4'h1;   // idcode-like default
   localparam logic [3:0] IR_CAPTURE   = 4'h1;   // fixed capture pattern
   localparam logic [3:0] IR_BYPASS    = 4'hf;
   localparam logic [3:0] IR_IDCODE    = 4'h1;
   localparam int ID_W      = 32;
   localparam int TLR_HIGH_CNT = 5;
   // tap states, one-hot
   typedef enum logic [15:0] {
      ST_TLR  = 16'h0001, ST_RTI  = 16'h0002, ST_SDRS = 16'h0004,
      ST_CDR  = 16'h0008, ST_SDR  = 16'h0010, ST_E1DR = 16'h0020,
      ST_PDR  = 16'h0040, ST_E2DR = 16'h0080, ST_UDR  = 16'h0100,
      ST_SIRS = 16'h0200, ST_CIR  = 16'h0400, ST_SIR  = 16'h0800,
      ST_E1IR = 16'h1000, ST_PIR  = 16'h2000, ST_E2IR = 16'h4000,
      ST_UIR  = 16'h8000
   } jtp_state_t;
endpackage

// ### hdl/jtp_tap.sv
// jtp_tap: boundary-scan test access port controller, sampled on clk_sys
`timescale 1ns/1ps
// How it works
// - five test pins; serial instruction and data scan
// - test reset clears controller asynchronously
// - undriven mode, data, reset pins read high
// - sample on rising, drive on falling
// - stopped test clock loses no state
// - data input shifts into selected register
// - output shifts on fall, else high-impedance
// - mode select decoded each test clock
// - held in reset, port stays passive
module jtp_tap #(
   parameter logic [31:0] ID_VALUE = 32'h0000_0001 // arbitrary value
) (
   input  wire logic clk_sys,
   input  wire logic arst_n,
   input  wire logic tck,
   input  wire logic tms,
   input  wire logic tdi,
   input  wire logic test_rst_n,
   output logic      tdo_o,
   output logic      tdo_oe_n,
   output logic      tap_in_reset
);
   // ****************************************************
   // input synchronisers
   // ****************************************************
   logic [2:0] s_tck, s_tms, s_tdi;
   logic [1:0] s_trst;
   logic       tck_lvl, tms_lvl, tdi_lvl;
   logic       trst_n_sys;
   // test reset acts asynchronously, release synchronised
   always_ff @(posedge clk_sys or negedge arst_n or negedge test_rst_n) begin
      if (!arst_n || !test_rst_n) begin
         s_trst <= 2'h0;
      end else begin
         s_trst <= {s_trst[0], 1'b1};
      end
   end
   assign trst_n_sys = s_trst[1];
   // three flops per pin; mode and data pins idle high per pull-up, clock idles low
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_tck <= 3'h0;
         s_tms <= 3'h7;
         s_tdi <= 3'h7;
      end else begin
         s_tck <= {s_tck[1:0], tck};
         s_tms <= {s_tms[1:0], tms};
         s_tdi <= {s_tdi[1:0], tdi};
      end
   end
   // filtered levels change only when stages two and three agree
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         tck_lvl <= 1'b0;
         tms_lvl <= 1'b1;
         tdi_lvl <= 1'b1;
      end else begin
         if (s_tck[1] == s_tck[2]) tck_lvl <= s_tck[2];
         if (s_tms[1] == s_tms[2]) tms_lvl <= s_tms[2];
         if (s_tdi[1] == s_tdi[2]) tdi_lvl <= s_tdi[2];
      end
   end
   logic tck_d, rise, fall;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) tck_d <= 1'b0;
      else         tck_d <= tck_lvl;
   end
   assign rise = tck_lvl & ~tck_d;
   assign fall = ~tck_lvl & tck_d;
   // ****************************************************
   // tap state machine
   // ****************************************************
   jtp_pkg::jtp_state_t state, next_state;
   // decode mode select on each rising edge
   always_comb begin
      next_state = state;
      case (state)
         jtp_pkg::ST_TLR:  next_state = tms_lvl ? jtp_pkg::ST_TLR
                                                : jtp_pkg::ST_RTI;
         jtp_pkg::ST_RTI:  next_state = tms_lvl ? jtp_pkg::ST_SDRS
                                                : jtp_pkg::ST_RTI;
         jtp_pkg::ST_SDRS: next_state = tms_lvl ? jtp_pkg::ST_SIRS
                                                : jtp_pkg::ST_CDR;
         jtp_pkg::ST_CDR:  next_state = tms_lvl ? jtp_pkg::ST_E1DR
                                                : jtp_pkg::ST_SDR;
         jtp_pkg::ST_SDR:  next_state = tms_lvl ? jtp_pkg::ST_E1DR
                                                : jtp_pkg::ST_SDR;
         jtp_pkg::ST_E1DR: next_state = tms_lvl ? jtp_pkg::ST_UDR
                                                : jtp_pkg::ST_PDR;
         jtp_pkg::ST_PDR:  next_state = tms_lvl ? jtp_pkg::ST_E2DR
                                                : jtp_pkg::ST_PDR;
         jtp_pkg::ST_E2DR: next_state = tms_lvl ? jtp_pkg::ST_UDR
                                                : jtp_pkg::ST_SDR;
         jtp_pkg::ST_UDR:  next_state = tms_lvl ? jtp_pkg::ST_SDRS
                                                : jtp_pkg::ST_RTI;
         jtp_pkg::ST_SIRS: next_state = tms_lvl ? jtp_pkg::ST_TLR
                                                : jtp_pkg::ST_CIR;
         jtp_pkg::ST_CIR:  next_state = tms_lvl ? jtp_pkg::ST_E1IR
                                                : jtp_pkg::ST_SIR;
         jtp_pkg::ST_SIR:  next_state = tms_lvl ? jtp_pkg::ST_E1IR
                                                : jtp_pkg::ST_SIR;
         jtp_pkg::ST_E1IR: next_state = tms_lvl ? jtp_pkg::ST_UIR
                                                : jtp_pkg::ST_PIR;
         jtp_pkg::ST_PIR:  next_state = tms_lvl ? jtp_pkg::ST_E2IR
                                                : jtp_pkg::ST_PIR;
         jtp_pkg::ST_E2IR: next_state = tms_lvl ? jtp_pkg::ST_UIR
                                                : jtp_pkg::ST_SIR;
         jtp_pkg::ST_UIR:  next_state = tms_lvl ? jtp_pkg::ST_SDRS
                                                : jtp_pkg::ST_RTI;
         default:          next_state = jtp_pkg::ST_TLR;
      endcase
   end
   // state only moves on test clock rise; a stopped clock holds it
   always_ff @(posedge clk_sys or negedge arst_n or negedge test_rst_n) begin
      if (!arst_n || !test_rst_n) begin
         state <= jtp_pkg::ST_TLR;
      end else if (!trst_n_sys) begin
         state <= jtp_pkg::ST_TLR;
      end else if (rise) begin
         state <= next_state;
      end
   end
   // ****************************************************
   // scan registers
   // ****************************************************
   logic [jtp_pkg::IR_W-1:0] ir_sh, ir;
   logic [jtp_pkg::ID_W-1:0] dr_sh;
   logic                     sel_id;
   assign sel_id = (ir == jtp_pkg::IR_IDCODE);
   // instruction shift and update
   always_ff @(posedge clk_sys or negedge arst_n or negedge test_rst_n) begin
      if (!arst_n || !test_rst_n) begin
         ir_sh <= jtp_pkg::IR_CAPTURE;
         ir    <= jtp_pkg::IR_RESET_VAL;
      end else if (!trst_n_sys || state == jtp_pkg::ST_TLR) begin
         ir    <= jtp_pkg::IR_RESET_VAL;
      end else if (rise) begin
         case (state)
            jtp_pkg::ST_CIR: ir_sh <= jtp_pkg::IR_CAPTURE;
            jtp_pkg::ST_SIR: begin
               ir_sh <= {tdi_lvl, ir_sh[jtp_pkg::IR_W-1:1]};
            end
            jtp_pkg::ST_UIR: ir    <= ir_sh;
            default:         ir_sh <= ir_sh;
         endcase
      end
   end
   // data register: identity when selected, else one-bit bypass
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         dr_sh <= '0;
      end else if (rise) begin
         if (state == jtp_pkg::ST_CDR) begin
            dr_sh <= sel_id ? ID_VALUE : '0;
         end else if (state == jtp_pkg::ST_SDR) begin
            if (sel_id) begin
               dr_sh <= {tdi_lvl, dr_sh[jtp_pkg::ID_W-1:1]};
            end else begin
               dr_sh[0] <= tdi_lvl;
            end
         end
      end
   end
   // ****************************************************
   // serial output, changes on falling test clock
   // ****************************************************
   logic shifting;
   assign shifting = (state == jtp_pkg::ST_SDR) || (state == jtp_pkg::ST_SIR);
   always_ff @(posedge clk_sys or negedge arst_n or negedge test_rst_n) begin
      if (!arst_n || !test_rst_n) begin
         tdo_o    <= 1'b0;
         tdo_oe_n <= 1'b1;
      end else if (!trst_n_sys) begin
         tdo_oe_n <= 1'b1;
      end else if (fall) begin
         tdo_oe_n <= ~shifting;
         // instruction bit in the instruction shift, else the data bit
         tdo_o    <= (state == jtp_pkg::ST_SIR) ? ir_sh[0]
                                                : dr_sh[0];
      end
   end
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) tap_in_reset <= 1'b1;
      else         tap_in_reset <= (state == jtp_pkg::ST_TLR);
   end
   // ****************************************************
   // assertions
   // ****************************************************
   int unsigned high_run;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) high_run <= 0;
      else if (rise) high_run <= tms_lvl ? high_run + 1 : 0;
   end
   // checks sample on the system clock; a test reset moves state between
   // two edges, so it cancels every check still in flight except a_trst_forces_tlr
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n || !test_rst_n);
   // a qualified test clock rise while shifting the instruction
   sequence s_rise_in_sir;
      rise && trst_n_sys && state == jtp_pkg::ST_SIR;
   endsequence
   // a qualified test clock rise from idle with mode select high
   sequence s_high_from_idle;
      rise && trst_n_sys && state == jtp_pkg::ST_RTI && tms_lvl;
   endsequence
   a_five_high_reset: assert property (
      high_run >= jtp_pkg::TLR_HIGH_CNT |-> state == jtp_pkg::ST_TLR)
      else $error("five high mode samples did not reach reset state");
   a_trst_forces_tlr: assert property (
      disable iff (!arst_n)
      !trst_n_sys |-> state == jtp_pkg::ST_TLR && tdo_oe_n)
      else $error("test reset did not hold controller in reset");
   a_hold_no_rise: assert property (
      trst_n_sys && !rise |=> $stable(state))
      else $error("state moved without test clock rise");
   a_oe_on_fall: assert property (
      trst_n_sys && !fall |=> $stable(tdo_oe_n) && $stable(tdo_o))
      else $error("serial output changed outside falling edge");
   a_hiz_idle: assert property (
      fall && trst_n_sys && !shifting |=> tdo_oe_n)
      else $error("output driven while not scanning");
   a_drive_scan: assert property (
      fall && trst_n_sys && shifting |=> !tdo_oe_n)
      else $error("output not driven while scanning");
   a_tms_decode: assert property (
      s_high_from_idle |=> state == jtp_pkg::ST_SDRS)
      else $error("mode select decoded wrongly from idle");
   a_ir_shift_in: assert property (
      s_rise_in_sir |=> ir_sh[jtp_pkg::IR_W-1] == $past(tdi_lvl))
      else $error("data input not shifted into instruction register");
endmodule

// ### sim/jtp_ctl.sv
// jtp_ctl: behavioural test controller driving the scan pins
`timescale 1ns/1ps
module jtp_ctl (
   input  wire logic clk_sys,
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   output logic      test_rst_n,
   input  wire logic tdo_o,
   input  wire logic tdo_oe_n
);
   logic last_tdo;
   logic tdo_line;
   // tdo has no pull-up: a released line shows the inverse of its last bit
   always_ff @(posedge clk_sys) begin
      if (!tdo_oe_n) last_tdo <= tdo_o;
   end
   assign tdo_line = tdo_oe_n ? ~last_tdo : tdo_o;
   // test reset held low from power-up until released
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      test_rst_n = 1'b0;
   end
   // one 160 ns test clock: fall with new tms/tdi, sample line, rise
   task automatic bit_io(input logic m, input logic d, output logic q,
                         output logic oe_n);
      @(posedge clk_sys);
      tck <= 1'b0;
      tms <= m;
      tdi <= d;
      repeat (10) @(posedge clk_sys);
      q = tdo_line;
      oe_n = tdo_oe_n;
      tck <= 1'b1;
      repeat (9) @(posedge clk_sys);
   endtask
   // clock stands still low between frames
   task automatic park(input int k);
      @(posedge clk_sys);
      tck <= 1'b0;
      repeat (k) @(posedge clk_sys);
   endtask
   // test reset pin, set on the next system clock edge
   task automatic trst(input logic v);
      @(posedge clk_sys);
      test_rst_n <= v;
   endtask
endmodule

// ### sim/testbench.sv
// testbench: scan traffic through the test port against a queue model
`timescale 1ns/1ps
module testbench;
   localparam logic [31:0] ID_V = 32'h5a3c_96e1; // arbitrary value
   logic clk_sys = 1'b0;
   logic arst_n;
   logic tck, tms, tdi, test_rst_n, tdo_o, tdo_oe_n, tap_in_reset;
   logic q, oe;
   logic [3:0] ir_m;
   int error_cnt = 0;
   int total_checks = 0;
   logic exp_q[$];
   always #4 clk_sys = ~clk_sys;
   jtp_tap #(.ID_VALUE(ID_V)) jtp_tap_inst (.clk_sys(clk_sys),
      .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi),
      .test_rst_n(test_rst_n), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n),
      .tap_in_reset(tap_in_reset));
   jtp_ctl jtp_ctl_inst (.clk_sys(clk_sys), .tck(tck), .tms(tms),
      .tdi(tdi), .test_rst_n(test_rst_n), .tdo_o(tdo_o),
      .tdo_oe_n(tdo_oe_n));
   task automatic cmp(input logic got, input logic exp, input string s);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: %s got %b exp %b", $time, s, got, exp);
      end
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // tms walk outside shift states, line must stay released
   task automatic walk(input logic [7:0] s, input int n);
      for (int i = 0; i < n; i++) begin
         jtp_ctl_inst.bit_io(s[i], 1'b1, q, oe);
         cmp(oe, 1'b1, "tdo released");
      end
   endtask
   // shift n bits lsb first, test clock stopped midway
   task automatic shift(input logic [31:0] d, input int n);
      for (int i = 0; i < n; i++) begin
         if (i == n / 2) jtp_ctl_inst.park(200);
         jtp_ctl_inst.bit_io(i == n - 1, d[i], q, oe);
         cmp(oe, 1'b0, "tdo driven in scan");
         cmp(q, exp_q.pop_front(), "tdo bit");
      end
   endtask
   task automatic ir_scan(input logic [3:0] v);
      walk(8'h03, 4);
      for (int i = 0; i < 4; i++) exp_q.push_back(jtp_pkg::IR_CAPTURE[i]);
      shift({28'h0, v}, 4);
      walk(8'h01, 2);
      ir_m = v;
   endtask
   task automatic dr_scan(input logic [31:0] d);
      logic [31:0] bp;
      bp = {d[30:0], 1'b0};
      walk(8'h01, 3);
      for (int i = 0; i < 32; i++)
         exp_q.push_back(ir_m == jtp_pkg::IR_IDCODE ? ID_V[i] : bp[i]);
      shift(d, 32);
      walk(8'h01, 2);
   endtask
   // watchdog
   initial begin
      repeat (40000) @(posedge clk_sys);
      error_cnt++;
      $display("ERROR %0t: timeout", $time);
      conclude();
   end
   initial begin
      arst_n = 1'b0;
      void'($urandom(66));
      repeat (4) @(posedge clk_sys);
      arst_n <= 1'b1;
      jtp_ctl_inst.trst(1'b1);
      repeat (2) @(posedge clk_sys);
      cmp(tap_in_reset, 1'b1, "reset state");
      cmp(tdo_oe_n, 1'b1, "released after reset");
      walk(8'h00, 1);
      ir_scan(jtp_pkg::IR_IDCODE);
      cmp(tap_in_reset, 1'b0, "left reset");
      dr_scan(32'($urandom));
      for (int k = 0; k < 4; k++) begin
         ir_scan(k == 0 ? jtp_pkg::IR_BYPASS : 4'($urandom));
         dr_scan(32'($urandom));
      end
      // five highs from the instruction shift state
      walk(8'h03, 4);
      for (int i = 0; i < 5; i++) begin
         jtp_ctl_inst.bit_io(1'b1, 1'b1, q, oe);
         cmp(tap_in_reset, i == 4, "five highs");
      end
      walk(8'h00, 1);
      ir_scan(jtp_pkg::IR_BYPASS);
      // test reset in mid data scan
      walk(8'h01, 3);
      repeat (3) jtp_ctl_inst.bit_io(1'b0, 1'b0, q, oe);
      jtp_ctl_inst.trst(1'b0);
      repeat (2) @(posedge clk_sys);
      cmp(tap_in_reset, 1'b1, "test reset");
      cmp(tdo_oe_n, 1'b1, "test reset release");
      jtp_ctl_inst.trst(1'b1);
      jtp_ctl_inst.park(4);
      walk(8'h00, 1);
      ir_m = jtp_pkg::IR_RESET_VAL;
      dr_scan(32'($urandom));
      conclude();
   end
endmodule
